// *** flash_pin_control.sv ***
// Purpose: Control-pin logic: merged resets, strapped identity, board input readback,
//          hardware write protection and row/column address capture.
// Assumes: All pins are asynchronous to CLK; cycle decode logic runs on CLK.
// Notes: Register port answers every read one cycle later; unmapped reads give zero.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module flash_pin_control (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PRIMARY_RESET_N,
  input wire logic SECONDARY_RESET_N,
  input wire logic INTERFACE_SELECT,
  input wire logic [3:0] STRAP_SELECT_CODE,
  input wire logic [4:0] BOARD_INPUT_LINES,
  input wire logic TOP_REGION_LOCK_N,
  input wire logic ARRAY_PROTECT_N,
  input wire logic ROW_COLUMN_SELECT,
  input wire logic [10:0] MUX_ADDRESS,
  input wire logic CYCLE_START,
  input wire logic [3:0] TARGET_SELECT_FIELD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic DEVICE_RESET,
  output logic PARALLEL_PROGRAM_MODE,
  output logic BOOT_DEVICE,
  output logic CYCLE_CLAIM,
  output logic [19:0] ASSEMBLED_ADDRESS,
  output logic ARRAY_WRITE_STROBE,
  output logic ARRAY_ERASE,
  output logic [19:0] ARRAY_ADDRESS,
  output logic READY
);
  logic [flash_pins_pkg::SYNC_W-1:0] pins_sync;
  logic prim_n;
  logic sec_n;
  logic mode_pin;
  logic [3:0] strap_pin;
  logic [4:0] board_input_lines;
  logic top_region_lock_n;
  logic protect_n;
  logic rc_sel;
  logic [10:0] mux_addr;
  logic blocked;

  logic dev_rst_next;
  logic mode_next;
  logic [3:0] code_next;
  logic [3:0] code_reg;
  logic boot_next;
  logic claim_next;
  logic [10:0] row_reg;
  logic [10:0] row_next;
  logic [8:0] col_reg;
  logic [8:0] col_next;
  logic [19:0] assembled_next;
  logic [19:0] target_reg;
  logic [19:0] target_next;
  flash_pins_pkg::op_state_t state_reg;
  flash_pins_pkg::op_state_t state_next;
  logic [19:0] op_addr_next;
  logic erase_reg;
  logic erase_next;
  logic strobe_next;
  logic discard_reg;
  logic discard_next;
  logic ready_next;
  logic [31:0] rdata_next;
  logic cmd_hit;

  pin_sync u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .d({PRIMARY_RESET_N, SECONDARY_RESET_N, INTERFACE_SELECT, STRAP_SELECT_CODE, BOARD_INPUT_LINES,
        TOP_REGION_LOCK_N, ARRAY_PROTECT_N, ROW_COLUMN_SELECT, MUX_ADDRESS}),
    .q(pins_sync)
  );

  assign {prim_n, sec_n, mode_pin, strap_pin, board_input_lines, top_region_lock_n, protect_n, rc_sel,
          mux_addr} = pins_sync;

  region_guard u_guard (
    .CLK(CLK),
    .RESET(RESET),
    .addr(ARRAY_ADDRESS),
    .top_lock_n(top_region_lock_n),
    .protect_n(protect_n),
    .blocked(blocked)
  );

  assign cmd_hit = REG_WR && (REG_ADDR == flash_pins_pkg::OFF_COMMAND) && !DEVICE_RESET &&
                   (state_reg == flash_pins_pkg::OP_READY) &&
                   (REG_WDATA[flash_pins_pkg::CMD_PROGRAM_BIT] || REG_WDATA[flash_pins_pkg::CMD_ERASE_BIT]);

  // Reset, mode and identity. Straps are re-caught during every reset so a
  // board that changes them while reset is held is followed.
  always_comb begin
    dev_rst_next = !prim_n || !sec_n;
    mode_next = DEVICE_RESET ? mode_pin : PARALLEL_PROGRAM_MODE;
    code_next = DEVICE_RESET ? strap_pin : code_reg;
    boot_next = (code_next == flash_pins_pkg::BOOT_CODE);
    claim_next = CYCLE_START && !DEVICE_RESET && !PARALLEL_PROGRAM_MODE &&
                 (TARGET_SELECT_FIELD == code_reg);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DEVICE_RESET <= 1'b1;
      PARALLEL_PROGRAM_MODE <= 1'b0;
      code_reg <= flash_pins_pkg::BOOT_CODE;
      BOOT_DEVICE <= 1'b1;
      CYCLE_CLAIM <= 1'b0;
    end else begin
      DEVICE_RESET <= dev_rst_next;
      PARALLEL_PROGRAM_MODE <= mode_next;
      code_reg <= code_next;
      BOOT_DEVICE <= boot_next;
      CYCLE_CLAIM <= claim_next;
    end
  end

  // Row holds the low address part, column the high part. The address pins
  // must be steady for two cycles around a select change, since the bus is
  // synchronised bit by bit.
  always_comb begin
    row_next = row_reg;
    col_next = col_reg;
    if (DEVICE_RESET) begin
      row_next = '0;
      col_next = '0;
    end else if (PARALLEL_PROGRAM_MODE) begin
      if (rc_sel) begin
        row_next = mux_addr;
      end else begin
        col_next = mux_addr[flash_pins_pkg::COL_W-1:0];
      end
    end
    assembled_next = {col_next, row_next};
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      row_reg <= '0;
      col_reg <= '0;
      ASSEMBLED_ADDRESS <= flash_pins_pkg::TARGET_RESET;
    end else begin
      row_reg <= row_next;
      col_reg <= col_next;
      ASSEMBLED_ADDRESS <= assembled_next;
    end
  end

  // Program and erase requests. A request waits one cycle for the guard to
  // judge the latched address, then either strobes the array or is dropped.
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    op_addr_next = ARRAY_ADDRESS;
    erase_next = erase_reg;
    strobe_next = 1'b0;
    discard_next = discard_reg;
    if (REG_WR && (REG_ADDR == flash_pins_pkg::OFF_TARGET)) begin
      target_next = REG_WDATA[19:0];
    end
    if (REG_WR && (REG_ADDR == flash_pins_pkg::OFF_STATUS) && REG_WDATA[flash_pins_pkg::ST_DISCARD_BIT]) begin
      discard_next = 1'b0;
    end
    unique case (state_reg)
      flash_pins_pkg::OP_READY: begin
        if (cmd_hit) begin
          op_addr_next = PARALLEL_PROGRAM_MODE ? ASSEMBLED_ADDRESS : target_reg;
          erase_next = REG_WDATA[flash_pins_pkg::CMD_ERASE_BIT];
          state_next = flash_pins_pkg::OP_WAIT;
        end
      end
      flash_pins_pkg::OP_WAIT: begin
        state_next = flash_pins_pkg::OP_DECIDE;
      end
      flash_pins_pkg::OP_DECIDE: begin
        if (blocked) begin
          discard_next = 1'b1;
        end else begin
          strobe_next = 1'b1;
        end
        state_next = flash_pins_pkg::OP_READY;
      end
    endcase
    if (DEVICE_RESET) begin
      state_next = flash_pins_pkg::OP_READY;
      strobe_next = 1'b0;
      discard_next = 1'b0;
    end
    ready_next = (state_next == flash_pins_pkg::OP_READY);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= flash_pins_pkg::OP_READY;
      target_reg <= flash_pins_pkg::TARGET_RESET;
      ARRAY_ADDRESS <= flash_pins_pkg::TARGET_RESET;
      erase_reg <= 1'b0;
      ARRAY_ERASE <= 1'b0;
      ARRAY_WRITE_STROBE <= 1'b0;
      discard_reg <= 1'b0;
      READY <= 1'b1;
    end else begin
      state_reg <= state_next;
      target_reg <= target_next;
      ARRAY_ADDRESS <= op_addr_next;
      erase_reg <= erase_next;
      ARRAY_ERASE <= erase_next;
      ARRAY_WRITE_STROBE <= strobe_next;
      discard_reg <= discard_next;
      READY <= ready_next;
    end
  end

  // Register reads. Board inputs are taken from the synchronised copy, so
  // they must be settled a few cycles ahead of the read.
  always_comb begin
    rdata_next = 32'h00000000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        flash_pins_pkg::OFF_READBACK: rdata_next = {27'h0000000, board_input_lines};
        flash_pins_pkg::OFF_STATUS: begin
          rdata_next[flash_pins_pkg::ST_MODE_BIT] = PARALLEL_PROGRAM_MODE;
          rdata_next[flash_pins_pkg::ST_BUSY_BIT] = !READY;
          rdata_next[flash_pins_pkg::ST_DISCARD_BIT] = discard_reg;
          rdata_next[flash_pins_pkg::ST_TOPLOCK_BIT] = top_region_lock_n;
          rdata_next[flash_pins_pkg::ST_PROTECT_BIT] = protect_n;
          rdata_next[flash_pins_pkg::ST_CODE_LSB +: 4] = code_reg;
        end
        flash_pins_pkg::OFF_TARGET: rdata_next = {12'h000, target_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 32'h00000000;
    end else begin
      REG_RDATA <= rdata_next;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_reset_merge;
    (!prim_n || !sec_n) |=> DEVICE_RESET;
  endproperty
  a_reset_merge: assert property (p_reset_merge) else $error("reset pin low did not reset device");

  property p_reset_clears_op;
    DEVICE_RESET |=> READY && !ARRAY_WRITE_STROBE;
  endproperty
  a_reset_clears_op: assert property (p_reset_clears_op) else $error("operation survived reset");

  property p_boot_code;
    $fell(DEVICE_RESET) |-> (BOOT_DEVICE == ($past(strap_pin) == flash_pins_pkg::BOOT_CODE));
  endproperty
  a_boot_code: assert property (p_boot_code) else $error("boot flag disagrees with strap code");

  property p_readback;
    REG_RD && (REG_ADDR == 8'h00) |=> REG_RDATA == {27'h0000000, $past(board_input_lines)};
  endproperty
  a_readback: assert property (p_readback) else $error("readback does not show board inputs");

  property p_readback_upper;
    REG_RD && (REG_ADDR == 8'h00) |=> REG_RDATA[31:5] == 27'h0000000;
  endproperty
  a_readback_upper: assert property (p_readback_upper) else $error("readback upper bits not zero");

  property p_protected_no_strobe;
    (state_reg == flash_pins_pkg::OP_DECIDE) &&
    flash_pins_pkg::region_protected(ARRAY_ADDRESS, $past(top_region_lock_n), $past(protect_n)) &&
    !DEVICE_RESET |=> !ARRAY_WRITE_STROBE && discard_reg;
  endproperty
  a_protected_no_strobe: assert property (p_protected_no_strobe) else $error("protected write reached array");

  property p_free_strobes;
    (state_reg == flash_pins_pkg::OP_DECIDE) && !blocked && !DEVICE_RESET |=> ARRAY_WRITE_STROBE;
  endproperty
  a_free_strobes: assert property (p_free_strobes) else $error("unprotected write was dropped");

  property p_back_to_ready;
    cmd_hit |=> !READY ##1 !READY ##1 READY;
  endproperty
  a_back_to_ready: assert property (p_back_to_ready) else $error("request did not return to ready");

  property p_row_capture;
    PARALLEL_PROGRAM_MODE && !DEVICE_RESET && rc_sel |=> ASSEMBLED_ADDRESS[10:0] == $past(mux_addr);
  endproperty
  a_row_capture: assert property (p_row_capture) else $error("row part not captured");

  property p_mode_hold;
    !DEVICE_RESET && !$past(DEVICE_RESET) |-> $stable(PARALLEL_PROGRAM_MODE);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

  property p_claim;
    CYCLE_START && !DEVICE_RESET && !PARALLEL_PROGRAM_MODE |=>
      CYCLE_CLAIM == ($past(TARGET_SELECT_FIELD) == $past(code_reg));
  endproperty
  a_claim: assert property (p_claim) else $error("cycle claim disagrees with target select");

  c_claim: cover property (CYCLE_START ##1 CYCLE_CLAIM);
  c_discard: cover property (cmd_hit ##3 discard_reg);
  c_program: cover property (cmd_hit ##3 ARRAY_WRITE_STROBE);
  c_par_mode: cover property (DEVICE_RESET ##1 !DEVICE_RESET && PARALLEL_PROGRAM_MODE);
endmodule : flash_pin_control

// *** flash_pins_pkg.sv ***
// Purpose: Shared constants for the flash control-pin logic.
// Assumes: One 200 MHz clock, register port with byte addresses.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package flash_pins_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned ROW_W = 11;
  localparam int unsigned COL_W = 9;
  localparam int unsigned LINES_W = 5;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned SYNC_W = 26;
  localparam logic [7:0] OFF_READBACK = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TARGET = 8'h08;
  localparam logic [7:0] OFF_COMMAND = 8'h0C;
  localparam int unsigned ST_MODE_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_DISCARD_BIT = 2;
  localparam int unsigned ST_TOPLOCK_BIT = 3;
  localparam int unsigned ST_PROTECT_BIT = 4;
  localparam int unsigned ST_CODE_LSB = 8;
  localparam int unsigned CMD_PROGRAM_BIT = 0;
  localparam int unsigned CMD_ERASE_BIT = 1;
  localparam logic [CODE_W-1:0] BOOT_CODE = 4'h0;
  localparam logic [3:0] TOP_REGION_TAG = 4'hF;
  localparam logic [ADDR_W-1:0] TARGET_RESET = 20'h00000;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 26'h0000000;

  typedef enum logic [1:0] {
    OP_READY,
    OP_WAIT,
    OP_DECIDE
  } op_state_t;

  // The top 64 KB block is the boot region; the protect pin guards every block below it.
  function automatic logic region_protected(input logic [ADDR_W-1:0] addr, input logic top_lock_n,
                                            input logic protect_n);
    logic in_top;
    in_top = (addr[ADDR_W-1:ADDR_W-4] == TOP_REGION_TAG);
    return in_top ? !top_lock_n : !protect_n;
  endfunction : region_protected
endpackage : flash_pins_pkg

// *** pin_sync.sv ***
// Purpose: Two-flop synchroniser for a group of slow, static pins.
// Assumes: Pins change rarely; a bus of them is only read once settled.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module pin_sync (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [flash_pins_pkg::SYNC_W-1:0] d,
  output logic [flash_pins_pkg::SYNC_W-1:0] q
);
  logic [flash_pins_pkg::SYNC_W-1:0] meta_reg;
  logic [flash_pins_pkg::SYNC_W-1:0] meta_next;
  logic [flash_pins_pkg::SYNC_W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      meta_reg <= flash_pins_pkg::SYNC_RESET;
      q <= flash_pins_pkg::SYNC_RESET;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule : pin_sync

// *** region_guard.sv ***
// Purpose: Registered verdict whether an array address is hardware protected.
// Assumes: Address and pin levels are stable one cycle before the verdict is used.
// Notes: Pin levels arrive already synchronised.
`timescale 1ns/1ps
module region_guard (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [flash_pins_pkg::ADDR_W-1:0] addr,
  input wire logic top_lock_n,
  input wire logic protect_n,
  output logic blocked
);
  logic blocked_next;

  always_comb begin
    blocked_next = flash_pins_pkg::region_protected(addr, top_lock_n, protect_n);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      blocked <= 1'b1;
    end else begin
      blocked <= blocked_next;
    end
  end
endmodule : region_guard

// *** host_cycle_master.sv ***
// Purpose: Host bus master model that opens bus cycles aimed at a target select code.
// Assumes: One cycle per call, launched by non-blocking assignment at a rising edge.
// Notes: Between cycles the field shows the inverse of the last code, so stale values never match.
`timescale 1ns/1ps
module host_cycle_master (
  input wire logic clk,
  output logic cycle_start,
  output logic [3:0] target_field
);
  initial begin
    cycle_start = 1'b0;
    target_field = 4'hF;
  end

  task automatic open_cycle(input logic [3:0] code);
    @(posedge clk);
    cycle_start <= 1'b1;
    target_field <= code;
    @(posedge clk);
    cycle_start <= 1'b0;
    target_field <= ~code;
  endtask : open_cycle
endmodule : host_cycle_master

// *** flash_pin_control_bench.sv ***
// Purpose: Self-checking bench for the flash control-pin logic.
// Assumes: Register port answers one cycle after a read strobe.
// Notes: Pins are moved only while no command is pending.
`timescale 1ns/1ps
module flash_pin_control_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic prim_n = 1'b1;
  logic sec_n = 1'b1;
  logic if_sel = 1'b0;
  logic rc_sel = 1'b0;
  logic top_lock_n = 1'b1;
  logic protect_n = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] strap = 4'h0;
  logic [4:0] lines = 5'h00;
  logic [10:0] mux = 11'h000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata, d;
  logic [19:0] asm_addr, arr_addr, a;
  logic [3:0] field;
  logic dev_rst, par_mode, boot, claim, wstrobe, erase, ready, cyc_start;
  int bad_count = 0;
  int compares = 0;
  int strobes = 0;
  int cycles = 0;
  int n;

  always #2.5 clk = ~clk;

  host_cycle_master host_cycle_master_i (.clk(clk), .cycle_start(cyc_start), .target_field(field));

  flash_pin_control flash_pin_control_i (
    .CLK(clk), .RESET(reset), .PRIMARY_RESET_N(prim_n), .SECONDARY_RESET_N(sec_n),
    .INTERFACE_SELECT(if_sel), .STRAP_SELECT_CODE(strap), .BOARD_INPUT_LINES(lines),
    .TOP_REGION_LOCK_N(top_lock_n), .ARRAY_PROTECT_N(protect_n), .ROW_COLUMN_SELECT(rc_sel),
    .MUX_ADDRESS(mux), .CYCLE_START(cyc_start), .TARGET_SELECT_FIELD(field), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .DEVICE_RESET(dev_rst),
    .PARALLEL_PROGRAM_MODE(par_mode), .BOOT_DEVICE(boot), .CYCLE_CLAIM(claim), .ASSEMBLED_ADDRESS(asm_addr),
    .ARRAY_WRITE_STROBE(wstrobe), .ARRAY_ERASE(erase), .ARRAY_ADDRESS(arr_addr), .READY(ready)
  );

  // The run should need well under a thousand cycles; this ceiling only catches a hang.
  always @(posedge clk) begin
    cycles++;
    if (wstrobe === 1'b1) begin
      strobes++;
    end
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr <= ad;
    wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ad, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_read

  task automatic wait_free;
    for (int k = 0; k < 20 && dev_rst !== 1'b0; k++) begin
      tick(1);
    end
    chk(dev_rst, 32'h0);
  endtask : wait_free

  task automatic pin_reset(input logic use_sec);
    @(posedge clk);
    if (use_sec) begin
      sec_n <= 1'b0;
    end else begin
      prim_n <= 1'b0;
    end
    tick(4);
    chk(dev_rst, 32'h1);
    @(posedge clk);
    prim_n <= 1'b1;
    sec_n <= 1'b1;
    wait_free();
  endtask : pin_reset

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wait_free();
    chk(boot, 32'h1);
    chk(par_mode, 32'h0);
    reg_read(flash_pins_pkg::OFF_STATUS, d);
    chk(d, 32'h00000018);
    $display("test defaults done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      lines <= i ? 5'h0A : 5'h15;
      tick(3);
      reg_read(flash_pins_pkg::OFF_READBACK, d);
      chk(d, i ? 32'h0000000A : 32'h00000015);
    end
    reg_read(8'h10, d);
    chk(d, 32'h00000000);
    $display("test readback done");
    host_cycle_master_i.open_cycle(4'h0);
    #1;
    chk(claim, 32'h1);
    host_cycle_master_i.open_cycle(4'h5);
    #1;
    chk(claim, 32'h0);
    $display("test claim done");
    for (int i = 0; i < 4; i++) begin
      a = (i < 2) ? 20'hF1230 : 20'h01230;
      @(posedge clk);
      top_lock_n <= (i != 0);
      protect_n <= (i != 2);
      tick(3);
      reg_write(flash_pins_pkg::OFF_TARGET, {12'h000, a});
      reg_read(flash_pins_pkg::OFF_TARGET, d);
      chk(d, {12'h000, a});
      n = strobes;
      reg_write(flash_pins_pkg::OFF_COMMAND, (i < 2) ? 32'h1 : 32'h2);
      tick(4);
      chk(strobes - n, i % 2);
      chk(ready, 32'h1);
      reg_read(flash_pins_pkg::OFF_STATUS, d);
      chk(d[2], (i % 2) == 0);
      chk(arr_addr, a);
      chk(erase, i >= 2);
      reg_write(flash_pins_pkg::OFF_STATUS, 32'h00000004);
    end
    $display("test protection done");
    @(posedge clk);
    strap <= 4'h3;
    pin_reset(1'b1);
    chk(boot, 32'h0);
    host_cycle_master_i.open_cycle(4'h3);
    #1;
    chk(claim, 32'h1);
    reg_read(flash_pins_pkg::OFF_STATUS, d);
    chk(d, 32'h00000318);
    $display("test secondary reset done");
    @(posedge clk);
    strap <= 4'h0;
    if_sel <= 1'b1;
    pin_reset(1'b0);
    chk(par_mode, 32'h1);
    reg_read(flash_pins_pkg::OFF_STATUS, d);
    chk(d, 32'h00000019);
    @(posedge clk);
    rc_sel <= 1'b1;
    mux <= 11'h5A5;
    tick(4);
    @(posedge clk);
    rc_sel <= 1'b0;
    mux <= 11'h1B3;
    tick(4);
    chk(asm_addr, {9'h1B3, 11'h5A5});
    host_cycle_master_i.open_cycle(4'h0);
    #1;
    chk(claim, 32'h0);
    reg_write(flash_pins_pkg::OFF_COMMAND, 32'h1);
    tick(4);
    chk(arr_addr, {9'h1B3, 11'h5A5});
    $display("test programming mode done");
    tally_and_finish();
  end
endmodule : flash_pin_control_bench
